// >>> design/pcg_pkg.sv
package pcg_pkg;
	localparam logic [11:0] PCG_OFF_GATE0 = 12'h000;
	localparam logic [11:0] PCG_OFF_GATE1 = 12'h004;
	localparam logic [11:0] PCG_OFF_PROT = 12'h008;
	localparam int PCG_BIT_MCSP_A = 12;
	localparam int PCG_BIT_ASER_B = 11;
	localparam int PCG_BIT_ASER_A = 10;
	localparam int PCG_BIT_SSER_A = 8;
	localparam int PCG_BIT_ASER_C = 5;
	localparam int PCG_BIT_TWB = 4;
	localparam int PCG_BIT_CONV = 3;
	localparam int PCG_BIT_TB_SYNC = 2;
	localparam int PCG_LSB_MOD = 0;
	localparam int PCG_LSB_CAP = 8;
	localparam int PCG_BIT_QE1 = 14;
	localparam int PCG_BIT_QE2 = 15;
	localparam int PCG_NUM_MOD = 6;
	localparam int PCG_NUM_CAP = 6;
	localparam logic [15:0] PCG_GATE0_WMASK = 16'h1d3c;
	localparam logic [15:0] PCG_GATE1_WMASK = 16'hff3f;
	localparam logic [15:0] PCG_GATE0_RST = 16'h0000;
	localparam logic [15:0] PCG_GATE1_RST = 16'h0000;
	localparam logic PCG_ASER_C_PRESENT = 1'b1;
endpackage : pcg_pkg

// >>> design/pcg_peripheral_clock_gating.sv
// Summary of operation
// [R1] bit 12 gates serial port A on low-speed clock
// [R2] bits 11,10 gate async ports B, A
// [R3] bit 8 gates sync serial A clock
// [R4] bit 5 gates async port C, reserved if absent
// [R5] bit 4 gates two-wire bus clock
// [R6] bit 3 gates converter on high-speed clock
// [R7] sync bit low halts modulator time-base clocks
// [R8] sync bit high starts time-bases aligned together
// [R9] software programs identical modulator prescalers
// [R10] software sequences enables, sync clear, setup, sync set
// [R11] second register layout: encoders, captures, modulators
// [R12] writes only land while protection lifted
// [R13] modulator enable feeds system clock
// [R14] reserved bits read zero, ignore writes
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
module pcg_peripheral_clock_gating
	import pcg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic protected_write_enable,
	input wire logic low_speed_periph_clock,
	input wire logic high_speed_periph_clock,
	input wire logic system_clock_out,
	input wire logic time_base_tick,
	output logic mc_serial_port_a_clock_en,
	output logic async_serial_b_clock_en,
	output logic async_serial_a_clock_en,
	output logic async_serial_c_clock_en,
	output logic sync_serial_a_clock_en,
	output logic two_wire_bus_clock_en,
	output logic converter_clock_en,
	output logic time_base_sync_start,
	output logic [5:0] modulator_clock_en,
	output logic [5:0] capture_unit_clock_en,
	output logic quad_encoder_1_clock_en,
	output logic quad_encoder_2_clock_en,
	output logic [5:0] time_base_clock_en,
	output logic mc_serial_port_a_clk,
	output logic async_serial_b_clk,
	output logic async_serial_a_clk,
	output logic async_serial_c_clk,
	output logic sync_serial_a_clk,
	output logic two_wire_bus_clk,
	output logic converter_clk,
	output logic [5:0] modulator_clk
);
	import pcg_pkg::*;

	logic [15:0] gate0_q, gate0_d;
	logic [15:0] gate1_q, gate1_d;
	logic [31:0] prdata_q, prdata_d;
	logic sync_arm_q, sync_arm_d;
	logic [15:0] wmask0;
	logic [15:0] wdata16;
	logic wr_acc, rd_acc, sel0, sel1, selp;

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && !penable && !pwrite;
	assign sel0 = (paddr == PCG_OFF_GATE0);
	assign sel1 = (paddr == PCG_OFF_GATE1);
	assign selp = (paddr == PCG_OFF_PROT);
	assign wdata16 = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};

	always_comb begin
		wmask0 = PCG_GATE0_WMASK;
		if (!PCG_ASER_C_PRESENT) begin
			wmask0[PCG_BIT_ASER_C] = 1'b0;
		end
	end

	// register writes
	always_comb begin
		gate0_d = gate0_q;
		gate1_d = gate1_q;
		// [R12] protected write gate
		if (wr_acc && protected_write_enable) begin
			if (sel0) begin
				// [R14] reserved bits masked
				gate0_d = (gate0_q & ~(wmask0 & {{8{pstrb[1]}}, {8{pstrb[0]}}}))
					| (wdata16 & wmask0);
			end else if (sel1) begin
				// [R11] second register layout
				gate1_d = (gate1_q & ~(PCG_GATE1_WMASK & {{8{pstrb[1]}}, {8{pstrb[0]}}}))
					| (wdata16 & PCG_GATE1_WMASK);
			end
		end
	end

	always_comb begin
		prdata_d = prdata_q;
		if (rd_acc) begin
			if (sel0) begin
				prdata_d = {16'h0000, gate0_q & wmask0};
			end else if (sel1) begin
				prdata_d = {16'h0000, gate1_q & PCG_GATE1_WMASK};
			end else if (selp) begin
				prdata_d = {31'h00000000, protected_write_enable};
			end else begin
				prdata_d = 32'h00000000;
			end
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !(sel0 || sel1 || selp);
	assign prdata = prdata_q;

	// sync arming: time bases start the cycle after the first tick seen while sync is set
	always_comb begin
		sync_arm_d = sync_arm_q;
		if (!gate0_q[PCG_BIT_TB_SYNC]) begin
			sync_arm_d = 1'b0;
		end else if (time_base_tick) begin
			sync_arm_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate0_q <= PCG_GATE0_RST;
			gate1_q <= PCG_GATE1_RST;
			prdata_q <= 32'h00000000;
			sync_arm_q <= 1'b0;
		end else if (clk_en) begin
			gate0_q <= gate0_d;
			gate1_q <= gate1_d;
			prdata_q <= prdata_d;
			sync_arm_q <= sync_arm_d;
		end
	end

	// [R1] serial port A enable
	assign mc_serial_port_a_clock_en = gate0_q[PCG_BIT_MCSP_A];
	// [R2] async ports B and A
	assign async_serial_b_clock_en = gate0_q[PCG_BIT_ASER_B];
	assign async_serial_a_clock_en = gate0_q[PCG_BIT_ASER_A];
	// [R3] sync serial enable
	assign sync_serial_a_clock_en = gate0_q[PCG_BIT_SSER_A];
	// [R4] async port C enable
	assign async_serial_c_clock_en = gate0_q[PCG_BIT_ASER_C] & PCG_ASER_C_PRESENT;
	// [R5] two-wire bus enable
	assign two_wire_bus_clock_en = gate0_q[PCG_BIT_TWB];
	// [R6] converter enable
	assign converter_clock_en = gate0_q[PCG_BIT_CONV];
	assign time_base_sync_start = gate0_q[PCG_BIT_TB_SYNC];
	assign modulator_clock_en = gate1_q[PCG_LSB_MOD +: PCG_NUM_MOD];
	assign capture_unit_clock_en = gate1_q[PCG_LSB_CAP +: PCG_NUM_CAP];
	assign quad_encoder_1_clock_en = gate1_q[PCG_BIT_QE1];
	assign quad_encoder_2_clock_en = gate1_q[PCG_BIT_QE2];
	// [R7] [R8] time-base gating, common arm
	assign time_base_clock_en = modulator_clock_en & {PCG_NUM_MOD{sync_arm_q}};

	// clock gates: enables are registers, AND gates stand for gating cells
	// [R1] [R2] [R3] [R4] [R5] low-speed gated clocks
	assign mc_serial_port_a_clk = low_speed_periph_clock & mc_serial_port_a_clock_en;
	assign async_serial_b_clk = low_speed_periph_clock & async_serial_b_clock_en;
	assign async_serial_a_clk = low_speed_periph_clock & async_serial_a_clock_en;
	assign async_serial_c_clk = low_speed_periph_clock & async_serial_c_clock_en;
	assign sync_serial_a_clk = low_speed_periph_clock & sync_serial_a_clock_en;
	assign two_wire_bus_clk = low_speed_periph_clock & two_wire_bus_clock_en;
	// [R6] high-speed gated clock
	assign converter_clk = high_speed_periph_clock & converter_clock_en;
	// [R13] system clock to modulators
	assign modulator_clk = {PCG_NUM_MOD{system_clock_out}} & modulator_clock_en;

	// [R12] write blocked without protection
	prot_block_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(clk_en && wr_acc && !protected_write_enable) |=> $stable(gate0_q) && $stable(gate1_q))
		else $error("write landed while protected");
	// [R14] reserved bits stay zero
	rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		gate0_q[9] == 1'b0 && gate0_q[7:6] == 2'b00 && gate0_q[1:0] == 2'b00
		&& gate1_q[7:6] == 2'b00)
		else $error("reserved bit set");
	// [R7] halted while sync low
	tb_halt_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		(clk_en && !time_base_sync_start) |=> time_base_clock_en == 6'h00)
		else $error("time base runs while sync low");
	// [R8] aligned start
	sequence sync_rise_s;
		$rose(time_base_sync_start) ##0 time_base_tick && clk_en;
	endsequence
	tb_start_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		sync_rise_s ##0 $stable(gate1_q) ##0 time_base_sync_start |=>
		(!time_base_sync_start || time_base_clock_en == modulator_clock_en))
		else $error("time bases not started together");
	tb_align_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(clk_en && time_base_sync_start && time_base_tick)
		|=> (!time_base_sync_start || time_base_clock_en == modulator_clock_en))
		else $error("time bases not aligned");

	// [R8] arming only on shared edge
	arm_on_tick_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(clk_en && !time_base_tick && !sync_arm_q) |=> !sync_arm_q)
		else $error("time base armed off the shared edge");
	// [R1] write reaches enable
	wr_gate0_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		(clk_en && wr_acc && protected_write_enable && sel0 && pstrb[1])
		|=> mc_serial_port_a_clock_en == $past(pwdata[PCG_BIT_MCSP_A]))
		else $error("serial port A enable not written");
	// [R6] converter enable follows write
	wr_conv_a: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(clk_en && wr_acc && protected_write_enable && sel0 && pstrb[0])
		|=> converter_clock_en == $past(pwdata[PCG_BIT_CONV]))
		else $error("converter enable not written");
	// [R11] second register write
	wr_gate1_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		(clk_en && wr_acc && protected_write_enable && sel1 && pstrb == 4'hf)
		|=> gate1_q == ($past(pwdata[15:0]) & PCG_GATE1_WMASK))
		else $error("second register not written");
	// [R13] modulator clock gated
	mod_clk_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		modulator_clk == ({6{system_clock_out}} & gate1_q[5:0]))
		else $error("modulator clock wrong");

	// accepted writes to each register
	sequence wr0_s;
		clk_en && wr_acc && protected_write_enable && sel0;
	endsequence
	sequence wr1_s;
		clk_en && wr_acc && protected_write_enable && sel1;
	endsequence

	// [R2] async port enables follow write
	wr_async_a: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		wr0_s ##0 pstrb[1] |=> async_serial_b_clock_en == $past(pwdata[PCG_BIT_ASER_B])
		&& async_serial_a_clock_en == $past(pwdata[PCG_BIT_ASER_A]))
		else $error("async port enables not written");

	// [R3] sync serial enable follows write
	wr_sync_ser_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		wr0_s ##0 pstrb[1] |=> sync_serial_a_clock_en == $past(pwdata[PCG_BIT_SSER_A]))
		else $error("sync serial enable not written");

	// [R4] port C enable follows write
	wr_port_c_a: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
		wr0_s ##0 pstrb[0]
		|=> async_serial_c_clock_en == ($past(pwdata[PCG_BIT_ASER_C]) && PCG_ASER_C_PRESENT))
		else $error("port C enable not written");

	// [R5] two-wire enable follows write
	wr_two_wire_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		wr0_s ##0 pstrb[0] |=> two_wire_bus_clock_en == $past(pwdata[PCG_BIT_TWB]))
		else $error("two-wire enable not written");

	// [R11] encoder enables follow write
	wr_encoder_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		wr1_s ##0 pstrb[1] |=> quad_encoder_2_clock_en == $past(pwdata[PCG_BIT_QE2])
		&& quad_encoder_1_clock_en == $past(pwdata[PCG_BIT_QE1]))
		else $error("encoder enables not written");

	// [R11] capture enables follow write
	wr_capture_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		wr1_s ##0 pstrb[1] |=> capture_unit_clock_en == $past(pwdata[13:8]))
		else $error("capture enables not written");

	// [R13] modulator enables follow write
	wr_mod_en_a: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
		wr1_s ##0 pstrb[0] |=> modulator_clock_en == $past(pwdata[5:0]))
		else $error("modulator enables not written");

	// [R11] unstrobed lane keeps its bits
	lane_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		wr1_s ##0 !pstrb[0] |=> gate1_q[7:0] == $past(gate1_q[7:0]))
		else $error("unstrobed lane changed");

	// [R12] unmapped writes dropped
	wr_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(clk_en && wr_acc && !(sel0 || sel1)) |=> $stable(gate0_q) && $stable(gate1_q))
		else $error("unmapped write changed a register");

	// [R12] frozen state while enable low
	freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		!clk_en |=> $stable(gate0_q) && $stable(gate1_q) && $stable(sync_arm_q))
		else $error("state moved while frozen");

	// [R12] protection level readable
	rd_prot_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		(clk_en && rd_acc && selp) |=> prdata == {31'h00000000, $past(protected_write_enable)})
		else $error("protection level misread");

	// [R14] reserved bits read zero
	rsvd_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		(clk_en && rd_acc && sel0) |=> prdata[9] == 1'b0 && prdata[7:6] == 2'b00
		&& prdata[1:0] == 2'b00 && prdata[31:16] == 16'h0000)
		else $error("reserved bit read as one");

	// [R11] second register read back
	rd_gate1_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		(clk_en && rd_acc && sel1) |=> prdata == {16'h0000, $past(gate1_q)})
		else $error("second register misread");

	// [R14] unmapped reads return zero
	rd_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		(clk_en && rd_acc && !(sel0 || sel1 || selp)) |=> prdata == 32'h00000000)
		else $error("unmapped read not zero");
endmodule : pcg_peripheral_clock_gating

// >>> dv/pcg_periph_model.sv
`timescale 1ns/100ps
module pcg_periph_model (
	input wire logic pclk,
	output logic ls_clk,
	output logic hs_clk,
	output logic tick
);
	logic [3:0] div_q = 4'h0;
	always_ff @(posedge pclk) begin
		div_q <= div_q + 4'h1;
	end
	assign hs_clk = div_q[0];
	assign ls_clk = div_q[1];
	assign tick = div_q == 4'hf;
endmodule : pcg_periph_model

// >>> dv/peripheral_clock_gating_test.sv
`timescale 1ns/100ps
module peripheral_clock_gating_test;
	import pcg_pkg::*;
	logic pclk, pready, pslverr, ls, hs, tick, cclk;
	logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pwe = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [7:0] en0;
	logic [5:0] men, cen, ten, lclk, mclk;
	logic [1:0] qe;
	logic [32:0] exp_q[$];
	int err_count = 0;
	int num_checks = 0;
	int n;
	pcg_periph_model peer (.pclk(pclk), .ls_clk(ls), .hs_clk(hs), .tick(tick));
	pcg_peripheral_clock_gating uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.protected_write_enable(pwe), .low_speed_periph_clock(ls),
		.high_speed_periph_clock(hs), .system_clock_out(pclk), .time_base_tick(tick),
		.mc_serial_port_a_clock_en(en0[6]), .async_serial_b_clock_en(en0[5]),
		.async_serial_a_clock_en(en0[4]), .async_serial_c_clock_en(en0[3]),
		.sync_serial_a_clock_en(en0[2]), .two_wire_bus_clock_en(en0[1]),
		.converter_clock_en(en0[0]), .time_base_sync_start(en0[7]),
		.modulator_clock_en(men), .capture_unit_clock_en(cen), .quad_encoder_1_clock_en(qe[0]),
		.quad_encoder_2_clock_en(qe[1]), .time_base_clock_en(ten),
		.mc_serial_port_a_clk(lclk[5]), .async_serial_b_clk(lclk[4]),
		.async_serial_a_clk(lclk[3]), .async_serial_c_clk(lclk[2]),
		.sync_serial_a_clk(lclk[1]), .two_wire_bus_clk(lclk[0]), .converter_clk(cclk),
		.modulator_clk(mclk));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	task automatic hang();
		err_count++;
		wrap_up();
	endtask : hang
	task automatic cmp(input logic [32:0] got, input logic [32:0] x);
		num_checks++;
		if (got !== x) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, x);
		end
	endtask : cmp
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) hang();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		xfer(1'b0, a, 32'h0);
	endtask : rd
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && exp_q.size() > 0) begin
			cmp({pslverr, prdata}, exp_q.pop_front());
		end
	end
	initial begin
		r = $urandom(1);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(PCG_OFF_GATE0, 33'h0);
		rd(PCG_OFF_GATE1, 33'h0);
		xfer(1'b1, PCG_OFF_GATE0, 32'hffffffff);
		rd(PCG_OFF_GATE0, {17'h0, PCG_GATE0_WMASK});
		cmp({25'h0, en0}, 33'h0ff);
		@(negedge pclk);
		cmp({27'h0, lclk}, {27'h0, {6{ls}}});
		@(posedge pclk);
		pwe <= 1'b0;
		xfer(1'b1, PCG_OFF_GATE0, 32'h0);
		rd(PCG_OFF_GATE0, {17'h0, PCG_GATE0_WMASK});
		rd(PCG_OFF_PROT, 33'h0);
		pwe <= 1'b1;
		r = $urandom;
		xfer(1'b1, PCG_OFF_GATE1, r);
		xfer(1'b1, PCG_OFF_GATE0, 32'h0);
		rd(PCG_OFF_GATE1, {17'h0, r[15:0] & PCG_GATE1_WMASK});
		cmp({19'h0, qe, cen, men}, {19'h0, r[15:8], r[5:0]});
		cmp({27'h0, ten}, 33'h0);
		xfer(1'b1, PCG_OFF_GATE0, 32'h0000000c);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (tick !== 1'b1 && n < 40);
		if (n >= 40) hang();
		@(posedge pclk);
		@(negedge pclk);
		cmp({27'h0, ten}, {27'h0, r[5:0]});
		cmp({32'h0, cclk}, {32'h0, hs});
		@(posedge pclk);
		#1 cmp({27'h0, mclk}, {27'h0, r[5:0]});
		@(posedge pclk);
		rd(12'h00c, {1'b1, 32'h0});
		wrap_up();
	end
endmodule : peripheral_clock_gating_test
